// file: src/clk_src_pkg.sv
// Contract
// - oscillator keeps running in wait mode
// - all three bus clock outputs continue during wait
// - stop mode halts oscillator unless configured on
// - block raises no interrupt requests
// - source option: internal, external, RC, crystal
// - reset selects internal oscillator source
// - frequency codes 4.0, 8.0, 12.8 MHz, reserved
// - crystal range code enables one amplifier
// - external enable claims first pin, starts switch
// - external enable starts no switch in monitor bypass
// - read-only engaged flag shows external source
// - each trim step changes period 0.2 percent
// - trim step scales with selected frequency
// - second pin role follows source and enable
// - internal source with external enable clear releases the first pin
// - two external edges, switch, engage, stop internal
// - both fields cleared returns to internal source
// - external clock mode forces clock output off
// - bus clock is quarter rate via half rate
package clk_src_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_TRIM           = 2'h1;
  localparam logic [1:0] ADDR_PIN_CONTROL    = 2'h2;

  localparam logic [1:0] SRC_INTERNAL  = 2'h0;
  localparam logic [1:0] SRC_EXT_CLOCK = 2'h1;
  localparam logic [1:0] SRC_RC        = 2'h2;
  localparam logic [1:0] SRC_CRYSTAL   = 2'h3;

  localparam logic [1:0] FREQ_4M0      = 2'h0;
  localparam logic [1:0] FREQ_8M0      = 2'h1;
  localparam logic [1:0] FREQ_12M8     = 2'h2;
  localparam logic [1:0] FREQ_RESERVED = 2'h3;

  localparam logic [1:0] RANGE_HIGH     = 2'h0;
  localparam logic [1:0] RANGE_MID      = 2'h1;
  localparam logic [1:0] RANGE_LOW      = 2'h2;
  localparam logic [1:0] RANGE_RESERVED = 2'h3;

  // status/control layout, msb first
  typedef struct packed {
    logic [1:0] option;
    logic [1:0] freq;
    logic [1:0] range;
    logic       ext_en;
    logic       engaged;
  } status_control_t;

  typedef struct packed {
    logic data;
    logic oe;
  } pin_drive_t;

  localparam status_control_t RESET_CONTROL = '{SRC_INTERNAL, FREQ_12M8, RANGE_HIGH, 1'b0, 1'b0};
  localparam logic [7:0]      RESET_TRIM    = 8'h80;
  localparam logic            RESET_OUT_EN  = 1'b0;

  // ---------------------------------------------------------------
  // timing: periods in 1/4096 of a CLK cycle
  // ---------------------------------------------------------------
  localparam longint CLK_HZ          = 50_000_000;
  localparam longint SUBUNITS_L      = 4096;
  localparam longint FREQ_4M0_HZ     = 4_000_000;
  localparam longint FREQ_8M0_HZ     = 8_000_000;
  localparam longint FREQ_12M8_HZ    = 12_800_000;
  localparam longint TRIM_PER_MILLE  = 2;
  localparam logic [16:0] SUBUNITS    = 17'(SUBUNITS_L);
  localparam logic [16:0] PERIOD_4M0  = 17'(CLK_HZ * SUBUNITS_L / FREQ_4M0_HZ);
  localparam logic [16:0] PERIOD_8M0  = 17'(CLK_HZ * SUBUNITS_L / FREQ_8M0_HZ);
  localparam logic [16:0] PERIOD_12M8 = 17'(CLK_HZ * SUBUNITS_L / FREQ_12M8_HZ);
  localparam logic [6:0]  STEP_4M0    = 7'(CLK_HZ * SUBUNITS_L / FREQ_4M0_HZ * TRIM_PER_MILLE / 1000);
  localparam logic [6:0]  STEP_8M0    = 7'(CLK_HZ * SUBUNITS_L / FREQ_8M0_HZ * TRIM_PER_MILLE / 1000);
  localparam logic [6:0]  STEP_12M8   = 7'(CLK_HZ * SUBUNITS_L / FREQ_12M8_HZ * TRIM_PER_MILLE / 1000);

  localparam logic [1:0] EDGES_BEFORE_SWITCH = 2'h2;

  typedef enum logic [2:0] {
    SW_INTERNAL = 3'b001,
    SW_ARMING   = 3'b010,
    SW_EXTERNAL = 3'b100
  } switch_state_t;

endpackage

// file: src/trim_oscillator.sv
`timescale 1ns/1ps
module trim_oscillator (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // control
  input  wire logic       run,
  input  wire logic [1:0] freq_sel,
  input  wire logic [7:0] trim,
  // one-cycle enable at the oscillator rate
  output logic            tick
);

  // ---------------------------------------------------------------
  // period table
  // ---------------------------------------------------------------
  // frequency code to period
  function automatic logic [16:0] base_period(input logic [1:0] f);
    case (f)
      clk_src_pkg::FREQ_4M0: base_period = clk_src_pkg::PERIOD_4M0;
      clk_src_pkg::FREQ_8M0: base_period = clk_src_pkg::PERIOD_8M0;
      default:               base_period = clk_src_pkg::PERIOD_12M8;
    endcase
  endfunction

  function automatic logic [6:0] trim_step(input logic [1:0] f);
    case (f)
      clk_src_pkg::FREQ_4M0: trim_step = clk_src_pkg::STEP_4M0;
      clk_src_pkg::FREQ_8M0: trim_step = clk_src_pkg::STEP_8M0;
      default:               trim_step = clk_src_pkg::STEP_12M8;
    endcase
  endfunction

  logic signed [7:0]  offs;
  logic signed [16:0] prod;
  logic [16:0]        period;
  logic [16:0]        sum;
  logic [16:0]        acc_d, acc_q;
  logic               tick_d, tick_q;

  // fractional accumulator; 0x80 is the untrimmed centre
  always_comb begin
    offs   = $signed({~trim[7], trim[6:0]});
    prod   = 17'(offs * $signed({1'b0, trim_step(freq_sel)}));
    period = base_period(freq_sel) + $unsigned(prod);
    sum    = acc_q + clk_src_pkg::SUBUNITS;
    acc_d  = sum;
    tick_d = 1'b0;
    if (!run) begin
      acc_d = 17'h00000;
    end else if (sum >= period) begin
      acc_d  = sum - period;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc_q  <= 17'h00000;
      tick_q <= 1'b0;
    end else begin
      acc_q  <= acc_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

  // shortest period exceeds two CLK cycles, so ticks never touch
  a_tick_spacing: assert property (@(posedge clk) disable iff (!resetn) tick_q |=> !tick_q)
    else $error("oscillator ticks back to back");
  a_halt_no_tick: assert property (@(posedge clk) disable iff (!resetn) !run |=> !tick_q ##1 !tick_q || run)
    else $error("halted oscillator still ticking");

endmodule

// file: src/glitch_free_switch.sv
`timescale 1ns/1ps
module glitch_free_switch (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // requests
  input  wire logic request,
  input  wire logic release_req,
  // source ticks
  input  wire logic int_tick,
  input  wire logic ext_tick,
  // results
  output logic      src_tick,
  output logic      engaged,
  output logic      int_run
);

  clk_src_pkg::switch_state_t state_d, state_q;
  logic [1:0] cnt_d, cnt_q;
  logic       engaged_d, engaged_q;
  logic       int_run_d, int_run_q;

  // handover happens only on a tick boundary of the incoming source
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    case (state_q)
      clk_src_pkg::SW_INTERNAL: begin
        if (request) begin
          state_d = clk_src_pkg::SW_ARMING;
          cnt_d   = 2'h0;
        end
      end
      clk_src_pkg::SW_ARMING: begin
        if (!request) begin
          state_d = clk_src_pkg::SW_INTERNAL;
        end else if (ext_tick) begin
          if (cnt_q == clk_src_pkg::EDGES_BEFORE_SWITCH - 2'h1) begin
            state_d = clk_src_pkg::SW_EXTERNAL;
          end else begin
            cnt_d = cnt_q + 2'h1;
          end
        end
      end
      clk_src_pkg::SW_EXTERNAL: begin
        if (release_req && int_tick) begin
          state_d = clk_src_pkg::SW_INTERNAL;
        end
      end
      default: state_d = clk_src_pkg::SW_INTERNAL;
    endcase
    engaged_d = (state_q == clk_src_pkg::SW_EXTERNAL) && (state_d == clk_src_pkg::SW_EXTERNAL);
    int_run_d = !(engaged_q && state_q == clk_src_pkg::SW_EXTERNAL && !release_req);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q   <= clk_src_pkg::SW_INTERNAL;
      cnt_q     <= 2'h0;
      engaged_q <= 1'b0;
      int_run_q <= 1'b1;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      engaged_q <= engaged_d;
      int_run_q <= int_run_d;
    end
  end

  // only one source feeds the tick path
  assign src_tick = (state_q == clk_src_pkg::SW_EXTERNAL) ? ext_tick : int_tick;
  assign engaged  = engaged_q;
  assign int_run  = int_run_q;

  a_two_edges: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == clk_src_pkg::SW_ARMING && state_d == clk_src_pkg::SW_EXTERNAL) |-> ext_tick && cnt_q == 2'h1)
    else $error("switch without two external edges");
  a_engage_before_stop: assert property (@(posedge clk) disable iff (!resetn)
    $fell(int_run_q) |-> $past(engaged_q, 1) && engaged_q)
    else $error("internal oscillator stopped before engage");
  a_no_request_stays: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == clk_src_pkg::SW_INTERNAL && !request) |=> state_q == clk_src_pkg::SW_INTERNAL)
    else $error("switch armed without request");

endmodule

// file: src/clk_source_select.sv
`timescale 1ns/1ps
module clk_source_select (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RESETN,
  // register port
  input  wire logic [1:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // mode and configuration
  input  wire logic       STOP_MODE,
  input  wire logic       STOP_MODE_OSCILLATOR_ENABLE,
  input  wire logic       MONITOR_BYPASS,
  // oscillator pins
  input  wire logic       FIRST_OSCILLATOR_PIN,
  output logic            FIRST_OSCILLATOR_PIN_CLOCK_ROLE,
  output logic            SECOND_OSCILLATOR_PIN,
  output logic            SECOND_OSCILLATOR_PIN_OE,
  output logic      [2:0] CRYSTAL_AMP_ENABLE,
  // clock enables and status
  output logic            FOUR_TIMES_BUS_CLOCK,
  output logic            TWO_TIMES_BUS_CLOCK,
  output logic            BUS_CLOCK_TICK,
  output logic            INTERNAL_SOURCE_CLOCK,
  output logic            INTERNAL_OSCILLATOR_RUNNING,
  output logic            EXTERNAL_CLOCK_ENGAGED
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // one amplifier per range
  function automatic logic [2:0] amp_onehot(input logic [1:0] r);
    case (r)
      clk_src_pkg::RANGE_HIGH: amp_onehot = 3'h1;
      clk_src_pkg::RANGE_MID:  amp_onehot = 3'h2;
      clk_src_pkg::RANGE_LOW:  amp_onehot = 3'h4;
      default:                 amp_onehot = 3'h0;
    endcase
  endfunction

  clk_src_pkg::status_control_t ctrl_d, ctrl_q, wr_view;
  logic [7:0]                   trim_d, trim_q;
  logic                         out_en_d, out_en_q;
  logic [7:0]                   rdata_d, rdata_q;
  logic [1:0]                   sync_d, sync_q;
  logic                         prev_d, prev_q;
  logic                         ext_tick;
  logic                         int_tick;
  logic                         src_tick;
  logic                         engaged;
  logic                         sw_int_run;
  logic                         osc_run;
  logic                         ext_request;
  logic                         release_req;
  logic [1:0]                   div_d, div_q;
  logic                         x4_d, x4_q;
  logic                         x2_d, x2_q;
  logic                         bus_d, bus_q;
  logic                         int_clk_d, int_clk_q;
  logic                         run_d, run_q;
  logic                         eng_d, eng_q;
  logic                         role_d, role_q;
  clk_src_pkg::pin_drive_t      second_d, second_q;
  logic [2:0]                   amp_d, amp_q;

  // ---------------------------------------------------------------
  // external source input
  // ---------------------------------------------------------------
  // two stages before any edge logic; only sync_q[1] is looked at
  always_comb begin
    sync_d = {sync_q[0], FIRST_OSCILLATOR_PIN};
    prev_d = sync_q[1];
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      sync_q <= 2'h0;
      prev_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign ext_tick = sync_q[1] & ~prev_q;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // reserved frequency and range codes are dropped, not stored
  always_comb begin
    wr_view  = clk_src_pkg::status_control_t'(WDATA);
    ctrl_d   = ctrl_q;
    trim_d   = trim_q;
    out_en_d = out_en_q;
    if (WR) begin
      case (ADDR)
        clk_src_pkg::ADDR_STATUS_CONTROL: begin
          ctrl_d.option = wr_view.option;
          if (wr_view.freq != clk_src_pkg::FREQ_RESERVED) begin
            ctrl_d.freq = wr_view.freq;
          end
          if (wr_view.range != clk_src_pkg::RANGE_RESERVED) begin
            ctrl_d.range = wr_view.range;
          end
          ctrl_d.ext_en = wr_view.ext_en;
        end
        clk_src_pkg::ADDR_TRIM:        trim_d   = WDATA;
        clk_src_pkg::ADDR_PIN_CONTROL: out_en_d = WDATA[0];
        default: ;
      endcase
    end
    ctrl_d.engaged = 1'b0;
    if (ctrl_d.option == clk_src_pkg::SRC_EXT_CLOCK) begin
      out_en_d = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ctrl_q   <= clk_src_pkg::RESET_CONTROL;
      trim_q   <= clk_src_pkg::RESET_TRIM;
      out_en_q <= clk_src_pkg::RESET_OUT_EN;
    end else begin
      ctrl_q   <= ctrl_d;
      trim_q   <= trim_d;
      out_en_q <= out_en_d;
    end
  end

  // read data only in the cycle after the strobe, unmapped reads zero
  always_comb begin
    rdata_d = 8'h00;
    if (RD) begin
      case (ADDR)
        clk_src_pkg::ADDR_STATUS_CONTROL: rdata_d = {ctrl_q.option, ctrl_q.freq, ctrl_q.range, ctrl_q.ext_en, engaged};
        clk_src_pkg::ADDR_TRIM:           rdata_d = trim_q;
        clk_src_pkg::ADDR_PIN_CONTROL:    rdata_d = {7'h00, out_en_q};
        default:                          rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // source selection
  // ---------------------------------------------------------------
  // monitor bypass masks the enable
  assign ext_request = ctrl_q.ext_en & ~MONITOR_BYPASS;
  assign release_req = (ctrl_q.option == clk_src_pkg::SRC_INTERNAL) && !ctrl_q.ext_en;
  // wait never gates, stop only without enable
  assign osc_run = sw_int_run & ~(STOP_MODE & ~STOP_MODE_OSCILLATOR_ENABLE);

  trim_oscillator u_osc (
    .clk      (CLK),
    .resetn   (RESETN),
    .run      (osc_run),
    .freq_sel (ctrl_q.freq),
    .trim     (trim_q),
    .tick     (int_tick)
  );

  glitch_free_switch u_switch (
    .clk         (CLK),
    .resetn      (RESETN),
    .request     (ext_request),
    .release_req (release_req),
    .int_tick    (int_tick),
    .ext_tick    (ext_tick),
    .src_tick    (src_tick),
    .engaged     (engaged),
    .int_run     (sw_int_run)
  );

  // ---------------------------------------------------------------
  // clock dividers
  // ---------------------------------------------------------------
  // half rate then quarter rate
  always_comb begin
    div_d     = src_tick ? div_q + 2'h1 : div_q;
    x4_d      = src_tick;
    x2_d      = src_tick & div_q[0];
    bus_d     = src_tick & (div_q == 2'h3);
    int_clk_d = int_tick;
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      div_q     <= 2'h0;
      x4_q      <= 1'b0;
      x2_q      <= 1'b0;
      bus_q     <= 1'b0;
      int_clk_q <= 1'b0;
    end else begin
      div_q     <= div_d;
      x4_q      <= x4_d;
      x2_q      <= x2_d;
      bus_q     <= bus_d;
      int_clk_q <= int_clk_d;
    end
  end

  // ---------------------------------------------------------------
  // pins and status
  // ---------------------------------------------------------------
  // pin clock output is one CLK wide per tick; duty is not 50 percent
  always_comb begin
    second_d = '{1'b0, 1'b0};
    case (ctrl_q.option)
      clk_src_pkg::SRC_CRYSTAL:   second_d = '{~sync_q[1], 1'b1};
      clk_src_pkg::SRC_EXT_CLOCK: second_d = '{1'b0, 1'b0};
      default:                    second_d = '{out_en_q & src_tick, out_en_q};
    endcase
    amp_d  = (ctrl_q.option == clk_src_pkg::SRC_CRYSTAL) ? amp_onehot(ctrl_q.range) : 3'h0;
    // first pin claimed off internal or while the external enable is set
    role_d = (ctrl_q.option != clk_src_pkg::SRC_INTERNAL) || ctrl_q.ext_en;
    run_d  = osc_run;
    eng_d  = engaged;
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      second_q <= '{1'b0, 1'b0};
      amp_q    <= 3'h0;
      role_q   <= 1'b0;
      run_q    <= 1'b1;
      eng_q    <= 1'b0;
    end else begin
      second_q <= second_d;
      amp_q    <= amp_d;
      role_q   <= role_d;
      run_q    <= run_d;
      eng_q    <= eng_d;
    end
  end

  assign RDATA                           = rdata_q;
  assign FIRST_OSCILLATOR_PIN_CLOCK_ROLE = role_q;
  assign SECOND_OSCILLATOR_PIN           = second_q.data;
  assign SECOND_OSCILLATOR_PIN_OE        = second_q.oe;
  assign CRYSTAL_AMP_ENABLE              = amp_q;
  assign FOUR_TIMES_BUS_CLOCK            = x4_q;
  assign TWO_TIMES_BUS_CLOCK             = x2_q;
  assign BUS_CLOCK_TICK                  = bus_q;
  assign INTERNAL_SOURCE_CLOCK           = int_clk_q;
  assign INTERNAL_OSCILLATOR_RUNNING     = run_q;
  assign EXTERNAL_CLOCK_ENGAGED          = eng_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_reserved_freq_kept: assert property (@(posedge CLK) disable iff (!RESETN)
    (WR && ADDR == clk_src_pkg::ADDR_STATUS_CONTROL && WDATA[5:4] == clk_src_pkg::FREQ_RESERVED)
    |=> ctrl_q.freq == $past(ctrl_q.freq))
    else $error("reserved frequency code stored");
  a_out_en_forced: assert property (@(posedge CLK) disable iff (!RESETN)
    ctrl_q.option == clk_src_pkg::SRC_EXT_CLOCK |-> !out_en_q)
    else $error("clock output enabled in external clock mode");
  a_crystal_pin_drive: assert property (@(posedge CLK) disable iff (!RESETN)
    ctrl_q.option == clk_src_pkg::SRC_CRYSTAL |=> SECOND_OSCILLATOR_PIN_OE && SECOND_OSCILLATOR_PIN == !$past(sync_q[1]))
    else $error("crystal amplifier output wrong");
  a_bus_quarter_rate: assert property (@(posedge CLK) disable iff (!RESETN)
    BUS_CLOCK_TICK |-> TWO_TIMES_BUS_CLOCK && FOUR_TIMES_BUS_CLOCK)
    else $error("bus tick outside half-rate tick");
  a_trim_read_back: assert property (@(posedge CLK) disable iff (!RESETN)
    (RD && ADDR == clk_src_pkg::ADDR_TRIM) |=> RDATA == $past(trim_q))
    else $error("trim read data wrong");
  a_stop_halts: assert property (@(posedge CLK) disable iff (!RESETN)
    (STOP_MODE && !STOP_MODE_OSCILLATOR_ENABLE) |=> !INTERNAL_OSCILLATOR_RUNNING)
    else $error("oscillator running in stop mode");
  a_engaged_read: assert property (@(posedge CLK) disable iff (!RESETN)
    (RD && ADDR == clk_src_pkg::ADDR_STATUS_CONTROL) |=> RDATA[0] == $past(engaged))
    else $error("engaged flag read wrong");
  a_role_released: assert property (@(posedge CLK) disable iff (!RESETN)
    (ctrl_q.option == clk_src_pkg::SRC_INTERNAL && !ctrl_q.ext_en) |=> !FIRST_OSCILLATOR_PIN_CLOCK_ROLE)
    else $error("first pin held as clock input on internal source");
  a_amp_off: assert property (@(posedge CLK) disable iff (!RESETN)
    ctrl_q.option != clk_src_pkg::SRC_CRYSTAL |=> CRYSTAL_AMP_ENABLE == 3'h0)
    else $error("crystal amplifier enabled off crystal source");
  a_ext_pin_free: assert property (@(posedge CLK) disable iff (!RESETN)
    ctrl_q.option == clk_src_pkg::SRC_EXT_CLOCK |=> !SECOND_OSCILLATOR_PIN_OE)
    else $error("second pin driven in external clock mode");
  a_wait_runs: assert property (@(posedge CLK) disable iff (!RESETN)
    (sw_int_run && !STOP_MODE) |=> INTERNAL_OSCILLATOR_RUNNING)
    else $error("oscillator halted outside stop mode");

endmodule

// file: sim/ext_clock_source.sv
`timescale 1ns/1ps
module ext_clock_source #(
  parameter int HALF = 3
) (
  // bench clock and control
  input  wire logic clk,
  input  wire logic run,
  // first oscillator pin level
  output logic      pin
);
  int cnt = 0;

  // ----------------------------------------
  // square wave, HALF clk cycles per level
  // ----------------------------------------
  // a stopped source stands low, so no stray edge can arm the switch
  always @(posedge clk) begin
    if (!run) begin
      cnt <= 0;
      pin <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      pin <= ~pin;
    end else begin
      cnt <= cnt + 1;
    end
  end

endmodule

// file: sim/tb_clk_source_select.sv
`timescale 1ns/1ps
module tb_clk_source_select;
  logic        clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
  logic        stop = 1'b0, stop_en = 1'b0, mon = 1'b0, ext_run = 1'b0;
  logic [1:0]  addr = 2'h0;
  logic [7:0]  wdata = 8'h00, rdata, st_m = 8'h20, tr_m = 8'h80, pc_m = 8'h00;
  logic [2:0]  amp;
  logic [31:0] seed = 32'h0000002C, r;
  logic        pin1, role, pin2, pin2_oe, x4, x2, bus, iclk, run, eng;
  int          bad_count = 0, tests_run = 0, f4, f2, fb, fi, fp, a;

  // ----------------------------------------
  // clock, partner and design
  // ----------------------------------------
  always #10 clk = ~clk;

  ext_clock_source #(.HALF(3)) partner (.clk(clk), .run(ext_run), .pin(pin1));

  clk_source_select dut (
    .CLK(clk), .RESETN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
    .STOP_MODE(stop), .STOP_MODE_OSCILLATOR_ENABLE(stop_en), .MONITOR_BYPASS(mon),
    .FIRST_OSCILLATOR_PIN(pin1), .FIRST_OSCILLATOR_PIN_CLOCK_ROLE(role), .SECOND_OSCILLATOR_PIN(pin2),
    .SECOND_OSCILLATOR_PIN_OE(pin2_oe), .CRYSTAL_AMP_ENABLE(amp), .FOUR_TIMES_BUS_CLOCK(x4),
    .TWO_TIMES_BUS_CLOCK(x2), .BUS_CLOCK_TICK(bus), .INTERNAL_SOURCE_CLOCK(iclk),
    .INTERNAL_OSCILLATOR_RUNNING(run), .EXTERNAL_CLOCK_ENGAGED(eng));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write, then the model takes the same byte
  task automatic wr(input logic [1:0] ad, input logic [7:0] d);
    @(posedge clk);
    addr  <= ad;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    if (ad == 2'h0) begin
      st_m[7:6] = d[7:6];
      if (d[5:4] != 2'h3) st_m[5:4] = d[5:4];
      if (d[3:2] != 2'h3) st_m[3:2] = d[3:2];
      st_m[1] = d[1];
      if (d[7:6] == 2'h1) pc_m = 8'h00;
    end
    if (ad == 2'h1) tr_m = d;
    if (ad == 2'h2 && st_m[7:6] != 2'h1) pc_m = {7'h00, d[0]};
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] ad, input logic [7:0] exp);
    @(posedge clk);
    addr <= ad;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 check(rdata, exp);
  endtask

  task automatic count(input int n);
    f4 = 0;
    f2 = 0;
    fb = 0;
    fi = 0;
    fp = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      f4 += x4;
      f2 += x2;
      fb += bus;
      fi += iclk;
      fp += pin2;
    end
  endtask

  task automatic wait_eng(input logic v);
    for (int i = 0; i < 300 && eng !== v; i++) @(posedge clk);
    #1 check({7'h00, eng}, {7'h00, v});
  endtask

  task automatic finish_test;
    if (bad_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard at 50000 cycles, over twice what the run needs
  initial begin
    #1_000_000;
    bad_count++;
    finish_test();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(2'h0, 8'h20);
    rd(2'h1, 8'h80);
    rd(2'h2, 8'h00);
    rd(2'h3, 8'h00);
    check({7'h00, run}, 8'h01);
    repeat (6) begin
      r = xs();
      wr(2'h1, r[7:0]);
      rd(2'h1, tr_m);
    end
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    rd(2'h1, tr_m);
    for (int c = 0; c < 4; c++) begin
      wr(2'h0, {2'h0, 2'(c), 2'(c), 2'h0});
      rd(2'h0, st_m);
    end
    // pin roles for every source option; option 0 also writes a reserved range
    for (int o = 0; o < 4; o++) begin
      wr(2'h0, {2'(o), 2'h2, 2'(o - 1), 2'h0});
      wr(2'h2, 8'h01);
      repeat (4) @(posedge clk);
      #1 check({7'h00, pin2_oe}, {7'h00, o != 1});
      check({7'h00, role}, {7'h00, o != 0});
      check({5'h00, amp}, (o == 3) ? 8'h04 : 8'h00);
      // the crystal amplifier inverts the idle low first pin
      if (o == 1 || o == 3) check({7'h00, pin2}, {7'h00, o == 3});
      rd(2'h2, pc_m);
      rd(2'h0, st_m);
    end
    // untrimmed, so the rate check does not depend on the last random trim
    wr(2'h1, 8'h80);
    wr(2'h0, 8'h20);
    count(400);
    check({7'h00, fp == f4}, 8'h01);
    check({7'h00, f4 > 80 && (f4 / 4 - fb) inside {[-1:1]}}, 8'h01);
    check({7'h00, (f4 / 2 - f2) inside {[-1:1]}}, 8'h01);
    @(posedge clk);
    stop <= 1'b1;
    count(20);
    count(200);
    check({7'h00, fi == 0}, 8'h01);
    stop_en <= 1'b1;
    count(20);
    count(200);
    check({7'h00, fi > 20}, 8'h01);
    stop    <= 1'b0;
    stop_en <= 1'b0;
    // nominal rate, then trim extremes, per frequency code; the extremes give
    // 1.254 against 0.744 of the untrimmed period for code 2, 1.253 against 0.745 for codes 0 and 1, about 168 percent
    for (int f = 0; f < 3; f++) begin
      wr(2'h0, {2'h0, 2'(f), 4'h0});
      wr(2'h1, 8'h80);
      count(2000);
      check({7'h00, (fi - ((f == 0) ? 160 : (f == 1) ? 320 : 512)) inside {[-2:2]}}, 8'h01);
      wr(2'h1, 8'h00);
      count(2000);
      a = fi;
      wr(2'h1, 8'hFF);
      count(2000);
      check({7'h00, a > fi + 50}, 8'h01);
      check({7'h00, (a * 100 / fi) inside {[163:174]}}, 8'h01);
    end
    wr(2'h1, 8'h80);
    // hand over to the external source and back
    wr(2'h0, 8'h62);
    ext_run <= 1'b1;
    wait_eng(1'b1);
    repeat (3) @(posedge clk);
    #1 check({7'h00, run}, 8'h00);
    st_m[0] = 1'b1;
    rd(2'h0, st_m);
    count(96);
    check({7'h00, fp == 0}, 8'h01);
    check({7'h00, f4 inside {[15:17]}}, 8'h01);
    check({7'h00, pin2_oe}, 8'h00);
    wr(2'h0, 8'h20);
    wait_eng(1'b0);
    check({7'h00, run}, 8'h01);
    st_m[0] = 1'b0;
    rd(2'h0, st_m);
    // monitor bypass masks the enable bit
    @(posedge clk);
    mon <= 1'b1;
    wr(2'h0, 8'h62);
    repeat (60) @(posedge clk);
    #1 check({7'h00, eng}, 8'h00);
    wr(2'h0, 8'h20);
    mon     <= 1'b0;
    ext_run <= 1'b0;
    finish_test();
  end
endmodule
